// File: rtl/sarrd_dev.sv
// Converter end: wake, sample, convert and shift out the result
// Overview of operation
// - Serial clock idles high between frames
// - Output changes on falling, host samples rising
// - Chip select fall starts sampling, enables output
// - Frame: four zeros then the result
// - First zero driven from chip select fall
// - Zeros two to four after falls 1-3
// - MSB on fall four, then downward
// - Output floats at select rise or EOC
// - Result is unsigned straight binary
// - Wakes automatically when chip select falls
// - EOC on last falling edge, then power down
// - Early select rise aborts and powers down
// - Host allows 720 ns before fall three (643 ns minimum)
// - Fall three ends sampling, starts conversion
// - Host toggles select once after power on; sarrd_host and the bench start straight with a conversion frame
`timescale 1ns/1ns
module sarrd_dev
	import sarrd_pkg::*;
(
	input wire logic mclk_i,
	input wire logic reset_i,
	sarrd_link_if.dev link,
	input wire logic [RES_BITS-1:0] analog_input_pin_i,
	output logic powered_o,
	output logic sampling_o
);
	logic [1:0] cs_sync_ff;
	logic [1:0] sclk_sync_ff;
	logic cs_d_ff;
	logic sclk_d_ff;
	sarrd_dev_t state_ff, nxt_state;
	logic [4:0] cnt_ff, nxt_cnt;
	logic [RES_BITS-1:0] shreg_ff, nxt_shreg;
	logic sdo_ff, nxt_sdo;
	logic oe_n_ff, nxt_oe_n;
	logic cs_fall, cs_rise, sclk_fall;

	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			cs_sync_ff <= 2'b11;
			sclk_sync_ff <= 2'b11;
			cs_d_ff <= 1'b1;
			sclk_d_ff <= 1'b1;
		end else begin
			cs_sync_ff <= {cs_sync_ff[0], link.cs_n};
			sclk_sync_ff <= {sclk_sync_ff[0], link.sclk};
			cs_d_ff <= cs_sync_ff[1];
			sclk_d_ff <= sclk_sync_ff[1];
		end
	end

	assign cs_fall = cs_d_ff & ~cs_sync_ff[1];
	assign cs_rise = ~cs_d_ff & cs_sync_ff[1];
	// Clock is gated by chip select; only falls inside the frame count
	assign sclk_fall = sclk_d_ff & ~sclk_sync_ff[1] & ~cs_sync_ff[1];

	always_comb begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		nxt_shreg = shreg_ff;
		nxt_sdo = sdo_ff;
		nxt_oe_n = oe_n_ff;
		if (cs_rise) begin
			nxt_state = SARRD_OFF;
			nxt_oe_n = 1'b1;
			nxt_cnt = CNT_ZERO;
		end else if (cs_fall) begin
			nxt_state = SARRD_SAMPLE;
			nxt_cnt = CNT_ZERO;
			nxt_sdo = 1'b0;
			nxt_oe_n = 1'b0;
		end else if (sclk_fall && state_ff != SARRD_OFF) begin
			nxt_cnt = cnt_ff + CNT_ONE;
			case (state_ff)
				SARRD_SAMPLE: begin
					nxt_sdo = 1'b0;
					if (nxt_cnt == CNT_HOLD) begin
						// Hold the input; straight binary code taken as is
						nxt_shreg = analog_input_pin_i;
						nxt_state = SARRD_CONVERT;
					end
				end
				SARRD_CONVERT: begin
					if (nxt_cnt == CNT_EOC) begin
						nxt_state = SARRD_OFF;
						nxt_oe_n = 1'b1;
					end else begin
						nxt_sdo = shreg_ff[RES_BITS-1];
						nxt_shreg = {shreg_ff[RES_BITS-2:0], 1'b0};
					end
				end
				default: nxt_state = SARRD_OFF;
			endcase
		end
	end

	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			state_ff <= SARRD_OFF;
			cnt_ff <= CNT_ZERO;
			shreg_ff <= RES_ZERO;
			sdo_ff <= 1'b0;
			oe_n_ff <= 1'b1;
		end else begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
			shreg_ff <= nxt_shreg;
			sdo_ff <= nxt_sdo;
			oe_n_ff <= nxt_oe_n;
		end
	end

	assign link.sdo = sdo_ff;
	assign link.sdo_oe_n = oe_n_ff;
	assign powered_o = state_ff != SARRD_OFF;
	assign sampling_o = state_ff == SARRD_SAMPLE;
endmodule

// File: rtl/sarrd_host.sv
// Host end: SPI mode 3 master that frames one conversion per request
`timescale 1ns/1ns
module sarrd_host
	import sarrd_pkg::*;
(
	input wire logic mclk_i,
	input wire logic reset_i,
	sarrd_link_if.host link,
	input wire logic start_i,
	output logic busy_o,
	output logic done_o,
	output logic [RES_BITS-1:0] result_o
);
	sarrd_host_t state_ff, nxt_state;
	logic [5:0] div_ff, nxt_div;
	logic [4:0] edge_ff, nxt_edge;
	logic [RES_BITS-1:0] shreg_ff, nxt_shreg;
	logic [RES_BITS-1:0] res_ff, nxt_res;
	logic done_ff, nxt_done;
	logic [1:0] sdo_sync_ff;

	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i)
			sdo_sync_ff <= 2'b00;
		else
			sdo_sync_ff <= {sdo_sync_ff[0], link.sdo_wire};
	end

	always_comb begin
		nxt_state = state_ff;
		nxt_div = div_ff;
		nxt_edge = edge_ff;
		nxt_shreg = shreg_ff;
		nxt_res = res_ff;
		nxt_done = 1'b0;
		case (state_ff)
			SARRD_IDLE: begin
				if (start_i) begin
					nxt_state = SARRD_SETUP;
					nxt_div = SETUP_W;
					nxt_edge = CNT_ZERO;
				end
			end
			// Stretched setup keeps fall three past the minimum sample time
			SARRD_SETUP: begin
				if (div_ff == DIV_ZERO) begin
					nxt_state = SARRD_LOW;
					nxt_div = HALF_DIV_W;
					nxt_edge = edge_ff + CNT_ONE;
				end else
					nxt_div = div_ff - 6'h01;
			end
			SARRD_LOW: begin
				if (div_ff == DIV_ZERO) begin
					nxt_state = SARRD_HIGH;
					nxt_div = HALF_DIV_W;
					// Synchroniser lag means this takes the bit of the previous fall
					if (edge_ff > CNT_MSB)
						nxt_shreg = {shreg_ff[RES_BITS-2:0], sdo_sync_ff[1]};
				end else
					nxt_div = div_ff - 6'h01;
			end
			SARRD_HIGH: begin
				if (div_ff == DIV_ZERO) begin
					if (edge_ff == CNT_EOC) begin
						nxt_state = SARRD_IDLE;
						nxt_res = shreg_ff;
						nxt_done = 1'b1;
					end else begin
						nxt_state = SARRD_LOW;
						nxt_div = (edge_ff == CNT_ONE) ? SETUP_W : HALF_DIV_W;
						nxt_edge = edge_ff + CNT_ONE;
					end
				end else
					nxt_div = div_ff - 6'h01;
			end
			default: nxt_state = SARRD_IDLE;
		endcase
	end

	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			state_ff <= SARRD_IDLE;
			div_ff <= DIV_ZERO;
			edge_ff <= CNT_ZERO;
			shreg_ff <= RES_ZERO;
			res_ff <= RES_ZERO;
			done_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			div_ff <= nxt_div;
			edge_ff <= nxt_edge;
			shreg_ff <= nxt_shreg;
			res_ff <= nxt_res;
			done_ff <= nxt_done;
		end
	end

	assign link.cs_n = (state_ff == SARRD_IDLE);
	assign link.sclk = (state_ff != SARRD_LOW);
	assign busy_o = state_ff != SARRD_IDLE;
	assign done_o = done_ff;
	assign result_o = res_ff;
endmodule

// File: rtl/sarrd_link_if.sv
// Serial link between host and converter
`timescale 1ns/1ns
interface sarrd_link_if;
	logic cs_n;
	logic sclk;
	logic sdo;
	logic sdo_oe_n;
	logic sdo_wire;
	// Pulled low when nobody drives
	assign sdo_wire = sdo_oe_n ? 1'b0 : sdo;
	modport dev (input cs_n, input sclk, output sdo, output sdo_oe_n);
	modport host (output cs_n, output sclk, input sdo_wire);
endinterface

// File: rtl/sarrd_pkg.sv
// Shared constants and types for the converter readout link
package sarrd_pkg;
	// Resolution of this build: 12 bits
	localparam int RES_BITS = 12;
	localparam int LEAD_ZEROS = 4;
	localparam int FRAME_EDGES = RES_BITS + LEAD_ZEROS;
	localparam int HOLD_EDGE = 3;
	localparam logic [4:0] CNT_ZERO = 5'h00;
	localparam logic [4:0] CNT_ONE = 5'h01;
	localparam logic [4:0] CNT_HOLD = 5'(HOLD_EDGE);
	localparam logic [4:0] CNT_MSB = 5'(LEAD_ZEROS);
	localparam logic [4:0] CNT_EOC = 5'(FRAME_EDGES);
	// Host timing
	localparam int MCLK_NS = 20;
	localparam int LINK_PERIOD_NS = 160;
	localparam int SAMPLE_MIN_NS = 643;
	localparam int HALF_DIV = LINK_PERIOD_NS / (2 * MCLK_NS);
	localparam int SAMPLE_CYC = (SAMPLE_MIN_NS + MCLK_NS - 1) / MCLK_NS;
	localparam logic [5:0] HALF_DIV_W = 6'(HALF_DIV - 1);
	localparam logic [5:0] SETUP_W = 6'(SAMPLE_CYC / 3);
	localparam logic [5:0] DIV_ZERO = 6'h00;
	localparam logic [RES_BITS-1:0] RES_ZERO = '0;
	typedef enum logic [1:0] {
		SARRD_OFF = 2'b00,
		SARRD_SAMPLE = 2'b01,
		SARRD_CONVERT = 2'b11
	} sarrd_dev_t;
	typedef enum logic [1:0] {
		SARRD_IDLE = 2'b00,
		SARRD_SETUP = 2'b01,
		SARRD_LOW = 2'b11,
		SARRD_HIGH = 2'b10
	} sarrd_host_t;
endpackage

// File: verif/sar_adc_serial_readout_tb.sv
// Bench: host and converter paired, plus a hand-driven converter
`timescale 1ns/1ns
module sar_adc_serial_readout_tb;
	import sarrd_pkg::*;
	localparam logic [RES_BITS-1:0] ROWS [4][2] = '{'{12'h000, 12'h000},
		'{12'h800, 12'h800}, '{12'h7ff, 12'h7ff}, '{12'hfff, 12'hfff}};
	logic mclk_i = 1'b0;
	logic reset_i = 1'b1;
	logic start_i = 1'b0;
	logic [RES_BITS-1:0] ain = '0, ain2 = '0;
	logic busy_o, done_o, pwr2, smp2;
	logic [RES_BITS-1:0] result_o;
	int fails = 0, compares = 0;
	sarrd_link_if l1(), l2();
	sarrd_dev i_sarrd_dev(.mclk_i, .reset_i, .link(l1.dev), .analog_input_pin_i(ain),
		.powered_o(), .sampling_o());
	sarrd_host i_sarrd_host(.mclk_i, .reset_i, .link(l1.host), .start_i, .busy_o,
		.done_o, .result_o);
	sarrd_dev i_sarrd_dev_b(.mclk_i, .reset_i, .link(l2.dev), .analog_input_pin_i(ain2),
		.powered_o(pwr2), .sampling_o(smp2));
	sarrd_properties i_sarrd_properties(.mclk_i, .reset_i, .cs_n(l1.cs_n), .sclk(l1.sclk),
		.sdo(l1.sdo), .sdo_oe_n(l1.sdo_oe_n));
	always #10 mclk_i = ~mclk_i;
	task automatic check(input string w, input logic [15:0] s, input logic [15:0] e);
		compares++;
		if (s !== e) begin
			fails++;
			$display("BAD %s expected %h seen %h", w, e, s);
		end
	endtask
	task automatic report_and_stop();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	initial begin
		repeat (3000) @(posedge mclk_i);
		fails++;
		report_and_stop();
	end
	// One conversion through the host end
	task automatic host_frame(input logic [RES_BITS-1:0] v, input logic [RES_BITS-1:0] e);
		ain <= v;
		start_i <= 1'b1;
		@(posedge mclk_i);
		start_i <= 1'b0;
		@(negedge mclk_i);
		check("busy", {busy_o, l1.cs_n}, 2'b10);
		do @(negedge mclk_i); while (done_o !== 1'b1);
		check("res", result_o, e);
		@(posedge mclk_i);
	endtask
	// Bench as host, since only it can break a frame early
	task automatic frame2(input int n, input logic [RES_BITS-1:0] v);
		logic [FRAME_EDGES-1:0] got = '0;
		// Input differs away from the hold edge, so an early or late capture shows
		ain2 <= ~v;
		l2.cs_n <= 1'b0;
		repeat (20) @(posedge mclk_i);
		for (int k = 1; k <= n; k++) begin
			if (k == 3) ain2 <= v;
			if (k == 4) ain2 <= ~v;
			l2.sclk <= 1'b0;
			repeat (4) @(posedge mclk_i);
			l2.sclk <= 1'b1;
			// Read a cycle after the rise to cover the converter's sync delay
			@(posedge mclk_i);
			got = {got[FRAME_EDGES-2:0], l2.sdo_wire};
			if (k == 2 || k == 3) check("phase", {pwr2, smp2}, {1'b1, k == 2});
			repeat (3) @(posedge mclk_i);
		end
		if (n == FRAME_EDGES) check("bits", got, {3'b000, v, 1'b0});
		check("live", {l2.sdo_oe_n, pwr2}, (n == FRAME_EDGES) ? 2'b10 : 2'b01);
		l2.cs_n <= 1'b1;
		repeat (6) @(posedge mclk_i);
		check("off", {l2.sdo_oe_n, pwr2}, 2'b10);
	endtask
	initial begin
		l2.cs_n = 1'b1;
		l2.sclk = 1'b1;
		repeat (20) @(posedge mclk_i);
		check("idle", {l1.cs_n, l1.sclk, l1.sdo_oe_n, busy_o}, 4'he);
		reset_i <= 1'b0;
		@(posedge mclk_i);
		foreach (ROWS[i]) begin
			host_frame(ROWS[i][0], ROWS[i][1]);
		end
		frame2(0, 12'h000);
		frame2(6, 12'hfff);
		frame2(FRAME_EDGES, 12'ha5c);
		// Reset in mid-frame must leave both ends idle with no false edge
		start_i <= 1'b1;
		@(posedge mclk_i);
		start_i <= 1'b0;
		repeat (40) @(posedge mclk_i);
		reset_i <= 1'b1;
		repeat (2) @(posedge mclk_i);
		reset_i <= 1'b0;
		@(posedge mclk_i);
		check("rst", {l1.cs_n, l1.sclk, l1.sdo_oe_n, busy_o, done_o}, 5'h1c);
		check("rst res", result_o, 12'h000);
		host_frame(12'h5a3, 12'h5a3);
		report_and_stop();
	end
endmodule

// File: verif/sarrd_properties.sv
// Link checks beside the host and converter ends
`timescale 1ns/1ns
module sarrd_properties
	import sarrd_pkg::*;
(
	input wire logic mclk_i,
	input wire logic reset_i,
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic sdo,
	input wire logic sdo_oe_n
);
	logic csd_ff, skd_ff;
	logic [4:0] fc_ff, nxt_fc;
	// Count kept past the select rise so frame length is judged there
	always_comb begin
		nxt_fc = fc_ff;
		if (csd_ff && !cs_n) begin
			nxt_fc = 5'h00;
		end else if (skd_ff && !sclk) begin
			nxt_fc = fc_ff + 5'h01;
		end
	end
	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			csd_ff <= 1'b1;
			skd_ff <= 1'b1;
			fc_ff <= 5'h00;
		end else begin
			csd_ff <= cs_n;
			skd_ff <= sclk;
			fc_ff <= nxt_fc;
		end
	end
	default clocking @(posedge mclk_i); endclocking
	default disable iff (reset_i);
	AST_IDLE: assert property (cs_n |-> sclk) else $error("idle clock low");
	AST_ON: assert property ($fell(cs_n) |-> ##[2:5] !(sdo_oe_n || sdo))
		else $error("no lead zero");
	AST_ZERO: assert property ($fell(sclk) && fc_ff < CNT_HOLD |-> ##5 !sdo)
		else $error("lead bit set");
	AST_DATA: assert property ($fell(sclk) && fc_ff >= CNT_HOLD && fc_ff < CNT_EOC - CNT_ONE
		|-> ##5 !sdo_oe_n) else $error("output off");
	AST_EOC: assert property ($fell(sclk) && fc_ff == CNT_EOC - CNT_ONE
		|-> ##[2:5] sdo_oe_n) else $error("on after end");
	AST_CSOFF: assert property ($rose(cs_n) |-> ##[1:5] sdo_oe_n) else $error("still on");
	AST_FRAME: assert property ($rose(cs_n) |-> fc_ff == CNT_EOC) else $error("short");
	AST_EXTRA: assert property ($fell(sclk) |-> fc_ff < CNT_EOC) else $error("extra");
	AST_CHG: assert property ($changed(sdo) |-> ($past(sclk, 4) && !$past(sclk, 3))
		|| ($past(cs_n, 4) && !$past(cs_n, 3))) else $error("sdo moved off a fall");
endmodule
